// ### rtl/spu_core.sv
// Notes on behaviour
// - Transmit holding byte sent LSB first
// - First received bit lands in bit 0
// - Receive read, transmit write share offset
// - Two divisor bytes form 16-bit divisor
// - Divisors 12, 6, 2304 give standard rates
// - Enable bits 0..3 map sources; 7..4 zero
// - Interrupt only for enabled pending sources
// - Status keeps updating whatever the enables
// - Four priority levels, line status highest
// - Identification read freezes top pending source
// - Bit 0 low when pending; 7..3 zero
// - Bits 2..0 encode the active source
// - Line status interrupt cleared by status read
// - Data available cleared by buffer read
// - Modem change cleared by modem status read
// - Divisor access bit selects latches
// - Empty flag sets on move, clears on load
// - Auxiliary output two gates the interrupt
//
// Local design decisions: the plain strobed port and the register addresses.
module spu_core #(
   parameter int DW = 16
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic       i_rxd,
   output logic            o_txd,
   input  wire logic [3:0] i_modem,
   output logic      [3:0] o_modem,
   output logic            o_irq
);
   typedef enum logic [1:0] {
      SPU_IDLE  = 2'b00,
      SPU_START = 2'b01,
      SPU_DATA  = 2'b10,
      SPU_STOP  = 2'b11
   } spu_state_e;

   logic [7:0]    lcr;
   logic [4:0]    mcr;
   logic [3:0]    ier;
   logic [7:0]    baud_divisor_low;
   logic [7:0]    baud_divisor_high;
   logic [7:0]    tx_holding_reg;
   logic [7:0]    rx_buffer_reg;
   logic          tx_holding_empty_flag;
   logic          tx_holding_empty_flag_int;
   logic          dr, oe, pe, fe, bi;
   logic          tick;
   logic          divisor_access_bit;
   logic          loop;
   spu_state_e    tx_st, rx_st;
   logic [3:0]    tx_cnt, rx_cnt;
   logic [2:0]    tx_idx, rx_idx;
   logic [7:0]    tx_shift, rx_shift;
   logic          tx_line, thr_move, rx_done;
   logic [2:0]    rx_sync;
   logic          rx_line, rx_in;
   logic [3:0]    mdm_lvl, mdm_src, mdm_prev, mdm_delta;
   logic          lsi_p, rda_p, tx_holding_empty_flag_p, msi_p, any_pend;
   logic [2:0]    iid;
   logic [7:0]    next_rdata;
   logic          wr_thr, rd_rbr, rd_iir, rd_lsr, rd_msr;

   assign divisor_access_bit = lcr[spu_pkg::LCR_DIVISOR_ACCESS_BIT];
   assign loop = mcr[spu_pkg::MCR_LOOP];
   // Same offset: writes reach the holding byte, reads the buffer
   assign wr_thr = i_wr && i_addr == spu_pkg::ADDR_DATA && !divisor_access_bit;
   assign rd_rbr = i_rd && i_addr == spu_pkg::ADDR_DATA && !divisor_access_bit;
   assign rd_iir = i_rd && i_addr == spu_pkg::ADDR_IIR;
   assign rd_lsr = i_rd && i_addr == spu_pkg::ADDR_LSR;
   assign rd_msr = i_rd && i_addr == spu_pkg::ADDR_MSR;

   spu_baud #(.W(DW)) spu_baud_i (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_div  ({baud_divisor_high, baud_divisor_low}),
      .o_tick (tick)
   );

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lcr               <= spu_pkg::RST_LCR;
         mcr               <= spu_pkg::RST_MCR;
         ier               <= spu_pkg::RST_IER;
         baud_divisor_low  <= spu_pkg::RST_DIV[7:0];
         baud_divisor_high <= spu_pkg::RST_DIV[15:8];
      end else if (i_wr) begin
         case (i_addr)
            spu_pkg::ADDR_DATA: begin
               if (divisor_access_bit) begin
                  baud_divisor_low <= i_wdata;
               end
            end
            spu_pkg::ADDR_IER: begin
               if (divisor_access_bit) begin
                  baud_divisor_high <= i_wdata;
               end else begin
                  ier <= i_wdata[3:0];
               end
            end
            spu_pkg::ADDR_LCR: lcr <= i_wdata;
            spu_pkg::ADDR_MCR: mcr <= i_wdata[4:0];
            default: ;
         endcase
      end
   end

   // Transmit holding byte and its empty flag
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_holding_reg        <= 8'h00;
         tx_holding_empty_flag <= 1'b1;
      end else begin
         if (wr_thr) begin
            tx_holding_reg <= i_wdata;
         end
         // A load in the move cycle keeps the new byte held
         if (wr_thr) begin
            tx_holding_empty_flag <= 1'b0;
         end else if (thr_move) begin
            tx_holding_empty_flag <= 1'b1;
         end
      end
   end

   assign thr_move = tx_st == SPU_IDLE && !tx_holding_empty_flag;

   // Holding-empty interrupt source; the set wins over either clear
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_holding_empty_flag_int <= 1'b0;
      end else if (thr_move) begin
         tx_holding_empty_flag_int <= 1'b1;
      end else if (wr_thr || (rd_iir && iid == spu_pkg::IID_TX_HOLDING_EMPTY_FLAG)) begin
         tx_holding_empty_flag_int <= 1'b0;
      end
   end

   // Transmitter, fixed 8 data bits and one stop bit
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_st    <= SPU_IDLE;
         tx_cnt   <= 4'h0;
         tx_idx   <= 3'h0;
         tx_shift <= 8'h00;
      end else begin
         case (tx_st)
            SPU_IDLE: begin
               tx_cnt <= 4'h0;
               tx_idx <= 3'h0;
               if (thr_move) begin
                  tx_shift <= tx_holding_reg;
                  tx_st    <= SPU_START;
               end
            end
            SPU_START: begin
               if (tick) begin
                  tx_cnt <= tx_cnt + 4'h1;
                  if (tx_cnt == spu_pkg::OVS_LAST) begin
                     tx_st <= SPU_DATA;
                  end
               end
            end
            SPU_DATA: begin
               if (tick) begin
                  tx_cnt <= tx_cnt + 4'h1;
                  if (tx_cnt == spu_pkg::OVS_LAST) begin
                     tx_shift <= {1'b0, tx_shift[7:1]};
                     tx_idx   <= tx_idx + 3'h1;
                     if (tx_idx == spu_pkg::BIT_LAST) begin
                        tx_st <= SPU_STOP;
                     end
                  end
               end
            end
            SPU_STOP: begin
               if (tick) begin
                  tx_cnt <= tx_cnt + 4'h1;
                  if (tx_cnt == spu_pkg::OVS_LAST) begin
                     tx_st <= SPU_IDLE;
                  end
               end
            end
            default: tx_st <= SPU_IDLE;
         endcase
      end
   end

   always_comb begin
      case (tx_st)
         SPU_START: tx_line = 1'b0;
         SPU_DATA:  tx_line = tx_shift[0];
         default:   tx_line = 1'b1;
      endcase
   end

   // Loopback holds the pin marking, even in break; outside loopback break forces it spacing
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_txd   <= 1'b1;
         o_modem <= 4'h0;
      end else begin
         o_txd   <= loop || (tx_line && !lcr[spu_pkg::LCR_BREAK]);
         o_modem <= loop ? 4'h0 : mcr[3:0];
      end
   end

   // Receive pin: accepted once the last two stages agree
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_sync <= 3'h7;
         rx_line <= 1'b1;
      end else begin
         rx_sync <= {rx_sync[1:0], i_rxd};
         if (rx_sync[1] == rx_sync[2]) begin
            rx_line <= rx_sync[2];
         end
      end
   end

   assign rx_in = loop ? tx_line : rx_line;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_st    <= SPU_IDLE;
         rx_cnt   <= 4'h0;
         rx_idx   <= 3'h0;
         rx_shift <= 8'h00;
      end else begin
         case (rx_st)
            SPU_IDLE: begin
               rx_cnt <= 4'h0;
               rx_idx <= 3'h0;
               if (!rx_in) begin
                  rx_st <= SPU_START;
               end
            end
            SPU_START: begin
               if (tick) begin
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt == spu_pkg::OVS_MID) begin
                     // A glitch shorter than half a bit is dropped
                     rx_st  <= rx_in ? SPU_IDLE : SPU_DATA;
                     rx_cnt <= 4'h0;
                  end
               end
            end
            SPU_DATA: begin
               if (tick) begin
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt == spu_pkg::OVS_LAST) begin
                     rx_shift <= {rx_in, rx_shift[7:1]};
                     rx_idx   <= rx_idx + 3'h1;
                     if (rx_idx == spu_pkg::BIT_LAST) begin
                        rx_st <= SPU_STOP;
                     end
                  end
               end
            end
            SPU_STOP: begin
               if (tick) begin
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt == spu_pkg::OVS_LAST) begin
                     rx_st <= SPU_IDLE;
                  end
               end
            end
            default: rx_st <= SPU_IDLE;
         endcase
      end
   end

   assign rx_done = rx_st == SPU_STOP && tick && rx_cnt == spu_pkg::OVS_LAST;

   // Line status; a new character wins over a read in the same cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_buffer_reg <= 8'h00;
         dr            <= 1'b0;
         oe            <= 1'b0;
         pe            <= 1'b0;
         fe            <= 1'b0;
         bi            <= 1'b0;
      end else if (rx_done) begin
         rx_buffer_reg <= rx_shift;
         dr            <= 1'b1;
         oe            <= oe || (dr && !rd_rbr);
         fe            <= fe || !rx_in;
         bi            <= bi || (!rx_in && rx_shift == 8'h00);
      end else begin
         if (rd_rbr) begin
            dr <= 1'b0;
         end
         if (rd_lsr) begin
            oe <= 1'b0;
            pe <= 1'b0;
            fe <= 1'b0;
            bi <= 1'b0;
         end
      end
   end

   // Modem inputs; loopback takes them from the control bits
   assign mdm_src = loop ? mcr[3:0] : mdm_lvl;

   generate
      for (genvar g = 0; g < 4; g++) begin : g_mdm
         logic [2:0] sy;
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               sy           <= 3'h0;
               mdm_lvl[g]   <= 1'b0;
               mdm_prev[g]  <= 1'b0;
               mdm_delta[g] <= 1'b0;
            end else begin
               sy <= {sy[1:0], i_modem[g]};
               if (sy[1] == sy[2]) begin
                  mdm_lvl[g] <= sy[2];
               end
               mdm_prev[g] <= mdm_src[g];
               if (mdm_src[g] != mdm_prev[g]) begin
                  mdm_delta[g] <= 1'b1;
               end else if (rd_msr) begin
                  mdm_delta[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   assign lsi_p    = ier[spu_pkg::IER_LSI] && (oe || pe || fe || bi);
   assign rda_p    = ier[spu_pkg::IER_RDA] && dr;
   assign tx_holding_empty_flag_p   = ier[spu_pkg::IER_TX_HOLDING_EMPTY_FLAG] && tx_holding_empty_flag_int;
   assign msi_p    = ier[spu_pkg::IER_MSI] && (|mdm_delta);
   assign any_pend = lsi_p || rda_p || tx_holding_empty_flag_p || msi_p;

   always_comb begin
      if (lsi_p) begin
         iid = spu_pkg::IID_LSI;
      end else if (rda_p) begin
         iid = spu_pkg::IID_RDA;
      end else if (tx_holding_empty_flag_p) begin
         iid = spu_pkg::IID_TX_HOLDING_EMPTY_FLAG;
      end else if (msi_p) begin
         iid = spu_pkg::IID_MSI;
      end else begin
         iid = spu_pkg::IID_NONE;
      end
   end

   always_comb begin
      case (i_addr)
         spu_pkg::ADDR_DATA:
            next_rdata = divisor_access_bit ? baud_divisor_low : rx_buffer_reg;
         spu_pkg::ADDR_IER:
            next_rdata = divisor_access_bit ? baud_divisor_high : {4'h0, ier};
         spu_pkg::ADDR_IIR: next_rdata = {5'h00, iid};
         spu_pkg::ADDR_LCR: next_rdata = lcr;
         spu_pkg::ADDR_MCR: next_rdata = {3'h0, mcr};
         spu_pkg::ADDR_LSR:
            next_rdata = {1'b0, tx_holding_empty_flag && tx_st == SPU_IDLE,
                          tx_holding_empty_flag, bi, fe, pe, oe, dr};
         spu_pkg::ADDR_MSR: next_rdata = {mdm_src, mdm_delta};
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_irq   <= 1'b0;
      end else begin
         o_rdata <= i_rd ? next_rdata : 8'h00;
         o_irq   <= any_pend && mcr[spu_pkg::MCR_OUT2];
      end
   end

   a_irq_gate: assert property (@(posedge i_clk) disable iff (i_rst)
      o_irq |-> $past(any_pend) && $past(mcr[spu_pkg::MCR_OUT2]))
      else $error("interrupt without enabled source or gate");
   a_ier_upper: assert property (@(posedge i_clk) disable iff (i_rst)
      i_rd && i_addr == spu_pkg::ADDR_IER && !divisor_access_bit |=> o_rdata[7:4] == 4'h0)
      else $error("enable register upper bits not zero");
   a_iir_pend: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_iir |=> o_rdata[0] == !$past(any_pend) && o_rdata[7:3] == 5'h00)
      else $error("identification pending bit wrong");
   a_iir_prio: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_iir && lsi_p |=> o_rdata[2:0] == 3'h6)
      else $error("line status not reported first");
   a_tx_holding_empty_flag_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_thr || (rd_iir && iid == spu_pkg::IID_TX_HOLDING_EMPTY_FLAG)) && !thr_move |=> !tx_holding_empty_flag_int)
      else $error("holding-empty interrupt not cleared");
   a_dr_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_rbr && !rx_done |=> !dr)
      else $error("data ready not cleared by buffer read");
   a_lsr_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_lsr && !rx_done |=> !(oe || pe || fe || bi))
      else $error("line errors not cleared by status read");
   a_tx_holding_empty_flag_move: assert property (@(posedge i_clk) disable iff (i_rst)
      thr_move && !wr_thr |=> tx_holding_empty_flag ##1 tx_st == SPU_START)
      else $error("holding move did not empty the register");
   c_rx_done: cover property (@(posedge i_clk) disable iff (i_rst) rx_done);
   c_irq_rise: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_irq));
   c_div_9600: cover property (@(posedge i_clk) disable iff (i_rst)
      {baud_divisor_high, baud_divisor_low} == spu_pkg::DIV_9600 && thr_move);
endmodule

// ### rtl/spu_pkg.sv
package spu_pkg;
   // Register indices on the byte port (base offset is index 0)
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_IER  = 3'h1;
   localparam logic [2:0] ADDR_IIR  = 3'h2;
   localparam logic [2:0] ADDR_LCR  = 3'h3;
   localparam logic [2:0] ADDR_MCR  = 3'h4;
   localparam logic [2:0] ADDR_LSR  = 3'h5;
   localparam logic [2:0] ADDR_MSR  = 3'h6;
   // Field positions
   localparam int IER_RDA   = 0;
   localparam int IER_TX_HOLDING_EMPTY_FLAG  = 1;
   localparam int IER_LSI   = 2;
   localparam int IER_MSI   = 3;
   localparam int LCR_DIVISOR_ACCESS_BIT  = 7;
   localparam int LCR_BREAK = 6;
   localparam int MCR_OUT2  = 3;
   localparam int MCR_LOOP  = 4;
   // Identification codes, bits 2..0
   localparam logic [2:0] IID_NONE = 3'h1;
   localparam logic [2:0] IID_LSI  = 3'h6;
   localparam logic [2:0] IID_RDA  = 3'h4;
   localparam logic [2:0] IID_TX_HOLDING_EMPTY_FLAG = 3'h2;
   localparam logic [2:0] IID_MSI  = 3'h0;
   // Reset values
   localparam logic [7:0]  RST_LCR = 8'h03;
   localparam logic [4:0]  RST_MCR = 5'h00;
   localparam logic [3:0]  RST_IER = 4'h0;
   localparam logic [15:0] RST_DIV = 16'h000C;
   // Reference divisors for a 1.8432 MHz baud clock
   localparam real         REF_CLK_MHZ = 1.8432;
   localparam logic [15:0] DIV_50      = 16'h0900;
   localparam logic [15:0] DIV_9600    = 16'h000C;
   localparam logic [15:0] DIV_19200   = 16'h0006;
   // Timing: sixteen samples per bit, mid-bit at sample 7
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID  = 4'h7;
   localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

// ### rtl/spu_baud.sv
module spu_baud #(
   parameter int W = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_div,
   output logic              o_tick
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   assign next_cnt = cnt + {{(W-1){1'b0}}, 1'b1};

   // A zero divisor stops the generator rather than running flat out
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt    <= '0;
         o_tick <= 1'b0;
      end else if (i_div == '0) begin
         cnt    <= '0;
         o_tick <= 1'b0;
      end else if (next_cnt >= i_div) begin
         cnt    <= '0;
         o_tick <= 1'b1;
      end else begin
         cnt    <= next_cnt;
         o_tick <= 1'b0;
      end
   end
endmodule

// ### sim/spu_peer.sv
module spu_peer #(
   parameter int BIT_CYC = 192
) (
   input  wire logic       i_clk,
   input  wire logic       i_txd,
   output logic            o_rxd,
   output logic      [7:0] o_byte,
   output int              o_count
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      o_rxd   = 1'b1;
      o_byte  = 8'h00;
      o_count = 0;
   end

   // A low stop level makes a framing fault on purpose; the line idles high after it
   task automatic send(input logic [7:0] b, input logic stop_lvl);
      logic [9:0] frame;
      frame = {stop_lvl, b, 1'b0};
      @(posedge i_clk);
      for (int i = 0; i < 10; i++) begin
         o_rxd <= frame[i];
         repeat (BIT_CYC) @(posedge i_clk);
      end
      o_rxd <= 1'b1;
   endtask

   // Samples each bit at its centre
   initial forever begin
      @(negedge i_txd);
      repeat (BIT_CYC / 2) @(posedge i_clk);
      if (i_txd === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge i_clk);
            o_byte[i] = i_txd;
         end
         repeat (BIT_CYC) @(posedge i_clk);
         o_count = o_count + 1;
      end
   end
endmodule

// ### sim/spu_core_bench.sv
module spu_core_bench;
   timeunit 1ns;
   timeprecision 1ns;

   // Divisor 12 gives 16 ticks of 12 cycles per bit
   localparam int BIT_CYC = 192;

   logic       clk;
   logic       rst;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       rxd;
   logic       txd;
   logic [3:0] modem_in;
   logic [3:0] modem_out;
   logic       irq;
   logic [7:0] peer_byte;
   int         peer_count;
   int         miscompares;
   int         checks_done;

   spu_core spu_core_i (
      .i_clk   (clk),
      .i_rst   (rst),
      .i_addr  (addr),
      .i_wdata (wdata),
      .i_wr    (wr),
      .i_rd    (rd),
      .o_rdata (rdata),
      .i_rxd   (rxd),
      .o_txd   (txd),
      .i_modem (modem_in),
      .o_modem (modem_out),
      .o_irq   (irq)
   );

   spu_peer #(.BIT_CYC(BIT_CYC)) spu_peer_i (
      .i_clk   (clk),
      .i_txd   (txd),
      .o_rxd   (rxd),
      .o_byte  (peer_byte),
      .o_count (peer_count)
   );

   task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cmp1(input string name, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input string name);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      cmp8(name, exp, rdata);
   endtask

   task automatic wait_irq(input logic exp);
      for (int n = 0; n < 4000 && irq !== exp; n++) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic test_regs;
      rd_reg(spu_pkg::ADDR_IER, 8'h00, "ier reset");
      rd_reg(spu_pkg::ADDR_IIR, 8'h01, "iir reset");
      wr_reg(spu_pkg::ADDR_LCR, 8'h83);
      rd_reg(spu_pkg::ADDR_DATA, 8'h0C, "div low reset");
      wr_reg(spu_pkg::ADDR_DATA, 8'h34);
      wr_reg(spu_pkg::ADDR_IER, 8'h12);
      rd_reg(spu_pkg::ADDR_DATA, 8'h34, "div low");
      rd_reg(spu_pkg::ADDR_IER, 8'h12, "div high");
      // Back to the 9600 baud divisor so the line speed stays legal
      wr_reg(spu_pkg::ADDR_DATA, spu_pkg::DIV_9600[7:0]);
      wr_reg(spu_pkg::ADDR_IER, spu_pkg::DIV_9600[15:8]);
      wr_reg(spu_pkg::ADDR_LCR, 8'h03);
      rd_reg(spu_pkg::ADDR_IER, 8'h00, "ier behind latch");
      wr_reg(spu_pkg::ADDR_IER, 8'hFF);
      rd_reg(spu_pkg::ADDR_IER, 8'h0F, "ier reserved");
   endtask

   task automatic test_tx;
      wr_reg(spu_pkg::ADDR_IER, 8'h02);
      wr_reg(spu_pkg::ADDR_MCR, 8'h08);
      settle(1);
      cmp8("modem out", 8'h08, {4'h0, modem_out});
      wr_reg(spu_pkg::ADDR_DATA, 8'hA5);
      wait_irq(1'b1);
      cmp1("irq holding empty", 1'b1, irq);
      rd_reg(spu_pkg::ADDR_IIR, 8'h02, "iir holding empty");
      settle(2);
      cmp1("irq after id read", 1'b0, irq);
      rd_reg(spu_pkg::ADDR_IIR, 8'h01, "iir after id read");
      for (int n = 0; n < 3000 && peer_count != 1; n++) settle(1);
      cmp8("tx byte", 8'hA5, peer_byte);
      settle(BIT_CYC);
      rd_reg(spu_pkg::ADDR_LSR, 8'h60, "lsr idle");
   endtask

   task automatic test_rx;
      wr_reg(spu_pkg::ADDR_IER, 8'h01);
      spu_peer_i.send(8'h3C, 1'b1);
      wait_irq(1'b1);
      rd_reg(spu_pkg::ADDR_IIR, 8'h04, "iir data");
      rd_reg(spu_pkg::ADDR_DATA, 8'h3C, "rx byte");
      settle(2);
      cmp1("irq after rx read", 1'b0, irq);
      rd_reg(spu_pkg::ADDR_IIR, 8'h01, "iir after rx read");
   endtask

   // Break pulls the pin low; loopback keeps it marking while the frame returns inside
   task automatic test_loop;
      wr_reg(spu_pkg::ADDR_LCR, 8'h43);
      settle(1);
      cmp1("txd in break", 1'b0, txd);
      wr_reg(spu_pkg::ADDR_LCR, 8'h03);
      wr_reg(spu_pkg::ADDR_MCR, 8'h18);
      wr_reg(spu_pkg::ADDR_DATA, 8'h5A);
      wait_irq(1'b1);
      cmp1("txd in loop", 1'b1, txd);
      cmp1("peer quiet in loop", 1'b1, peer_count == 1);
      rd_reg(spu_pkg::ADDR_IIR, 8'h04, "iir loop data");
      rd_reg(spu_pkg::ADDR_DATA, 8'h5A, "loop byte");
      wr_reg(spu_pkg::ADDR_MCR, 8'h08);
      wr_reg(spu_pkg::ADDR_IER, 8'h0A);
      rd_reg(spu_pkg::ADDR_IIR, 8'h02, "iir loop empty");
      rd_reg(spu_pkg::ADDR_MSR, 8'h08, "msr loop change");
      rd_reg(spu_pkg::ADDR_IIR, 8'h01, "iir loop clean");
   endtask

   // Framing fault raises line status and data together
   task automatic test_priority;
      wr_reg(spu_pkg::ADDR_IER, 8'h0F);
      spu_peer_i.send(8'h81, 1'b0);
      wait_irq(1'b1);
      rd_reg(spu_pkg::ADDR_IIR, 8'h06, "iir line status");
      rd_reg(spu_pkg::ADDR_LSR, 8'h69, "lsr framing");
      rd_reg(spu_pkg::ADDR_IIR, 8'h04, "iir next data");
      rd_reg(spu_pkg::ADDR_DATA, 8'h81, "rx faulty byte");
      rd_reg(spu_pkg::ADDR_IIR, 8'h01, "iir drained");
   endtask

   task automatic test_modem;
      wr_reg(spu_pkg::ADDR_IER, 8'h00);
      @(posedge clk);
      modem_in <= 4'h2;
      settle(8);
      cmp1("irq masked", 1'b0, irq);
      rd_reg(spu_pkg::ADDR_MSR, 8'h22, "msr masked");
      wr_reg(spu_pkg::ADDR_IER, 8'h08);
      wr_reg(spu_pkg::ADDR_MCR, 8'h00);
      @(posedge clk);
      modem_in <= 4'h0;
      settle(8);
      cmp1("irq gated", 1'b0, irq);
      rd_reg(spu_pkg::ADDR_IIR, 8'h00, "iir modem");
      wr_reg(spu_pkg::ADDR_MCR, 8'h08);
      settle(2);
      cmp1("irq ungated", 1'b1, irq);
      rd_reg(spu_pkg::ADDR_MSR, 8'h02, "msr change");
      settle(2);
      cmp1("irq after msr read", 1'b0, irq);
      rd_reg(spu_pkg::ADDR_IIR, 8'h01, "iir after msr read");
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Four frames of about 2000 cycles each fit well inside this span
   // The framing fault may restart the receiver, so it runs after the loop test
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      end_sim();
   end

   initial begin
      miscompares = 0;
      checks_done = 0;
      rst      = 1'b1;
      addr     = 3'h0;
      wdata    = 8'h00;
      wr       = 1'b0;
      rd       = 1'b0;
      modem_in = 4'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      settle(1);
      cmp1("irq reset", 1'b0, irq);
      test_regs();
      test_tx();
      test_rx();
      test_loop();
      test_priority();
      test_modem();
      end_sim();
   end
endmodule
